// File: rtl/hs_serdes_rx_cdr_tx_tap_regs.sv
`timescale 1ns/1ps
`include "hsrtr_defs.svh"

module hs_serdes_rx_cdr_tx_tap_regs (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Management port
   input wire logic [4:0] port_addr,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // Receive and CDR controls
   output logic adc_track_force,
   output logic [2:0] rx_precursor_eq_level,
   output logic rx_precursor_eq_off,
   output logic [3:0] rx_precursor_eq_ninths,
   output logic [1:0] cdr_loop_order_select,
   output logic cdr_second_order,
   output logic cdr_track_2x,
   output logic cdr_order_reserved,
   output logic [1:0] cdr_vote_threshold,
   output logic [5:0] cdr_vote_count,
   output logic hf_peaking_off,
   output logic short_channel_cdr_mode,
   output logic [4:0] tx_cursor_reduction,
   output logic tx_cursor_reserved,
   // Transmit taps and polarity
   output logic rx_pair_invert,
   output logic tx_pair_invert,
   output logic [4:0] tx_post1_tap_weight,
   output logic [3:0] tx_pre_tap_weight,
   output logic [3:0] tx_post2_tap_weight,
   output logic tx_post1_negative,
   output logic [3:0] tx_post1_steps,
   output logic tx_pre_negative,
   output logic [3:0] tx_pre_steps,
   output logic tx_post2_negative,
   output logic [3:0] tx_post2_steps,
   // Differential pairs through the polarity swap
   input wire logic hs_rx_p,
   input wire logic hs_rx_n,
   output logic rx_data_p,
   output logic rx_data_n,
   input wire logic tx_data_p,
   input wire logic tx_data_n,
   output logic hs_tx_p,
   output logic hs_tx_n
);
   import hsrtr_pkg::*;

   // Sign of a sign/magnitude tap, narrow fields sit in the low bits
   function automatic logic tap_negative(input logic [4:0] f,
                                         input logic narrow);
      tap_negative = narrow ? f[3] : f[4];
   endfunction

   function automatic logic [3:0] tap_steps(input logic [4:0] f,
                                            input logic narrow);
      tap_steps = narrow ? {1'b0, f[2:0]} : f[3:0];
   endfunction

   hsrtr_state_t state;
   logic mdc_prev;
   logic mdc_rise;
   logic [5:0] ones_cnt;
   logic [3:0] hdr_cnt;
   logic [11:0] hdr_shift;
   logic ta_cnt;
   logic [4:0] data_cnt;
   logic [15:0] data_shift;
   logic [15:0] addr_reg;
   logic ours;
   logic is_read;
   hsrtr_op_t op;
   logic wr_en;
   logic [15:0] rd_data;
   logic [15:0] rxcdr_reg;
   logic [15:0] tap_reg;
   logic [11:0] next_hdr;

   assign mdc_rise = mdc && !mdc_prev;
   assign next_hdr = {hdr_shift[10:0], mdio_in};

   hsrtr_regfile u_regfile (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wr_en(wr_en),
      .wr_addr(addr_reg),
      .wr_data({data_shift[14:0], mdio_in}),
      .rd_addr(addr_reg),
      .rd_data(rd_data),
      .rxcdr_reg(rxcdr_reg),
      .tap_reg(tap_reg)
   );

   // Commit on the mdc edge that samples the last data bit
   assign wr_en = mdc_rise && state == HSRTR_DATA && ours &&
                  op == HSRTR_OP_WRITE &&
                  data_cnt == `HSRTR_DATA_BITS - 5'd1;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mdc_prev <= 1'b0;
      end else begin
         mdc_prev <= mdc;
      end
   end

   // Frame sequencer, one step per rising mdc
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= HSRTR_PRE;
         ones_cnt <= 6'h00;
         hdr_cnt <= 4'h0;
         hdr_shift <= 12'h000;
         ta_cnt <= 1'b0;
         data_cnt <= 5'h00;
         data_shift <= 16'h0000;
         ours <= 1'b0;
         op <= HSRTR_OP_ADDR;
      end else if (mdc_rise) begin
         case (state)
            HSRTR_PRE: begin
               if (mdio_in) begin
                  if (ones_cnt != `HSRTR_PREAMBLE_BITS) begin
                     ones_cnt <= ones_cnt + 6'h01;
                  end
               end else if (ones_cnt == `HSRTR_PREAMBLE_BITS) begin
                  state <= HSRTR_ST;
               end else begin
                  ones_cnt <= 6'h00;
               end
            end
            HSRTR_ST: begin
               // Only the extended-address start code is served
               ones_cnt <= 6'h00;
               hdr_cnt <= 4'h0;
               state <= mdio_in ? HSRTR_PRE : HSRTR_HDR;
            end
            HSRTR_HDR: begin
               hdr_shift <= next_hdr;
               hdr_cnt <= hdr_cnt + 4'h1;
               if (hdr_cnt == `HSRTR_HDR_BITS - 4'h1) begin
                  op <= hsrtr_op_t'(next_hdr[11:10]);
                  ours <= next_hdr[9:5] == port_addr &&
                          next_hdr[4:0] == `HSRTR_DEVAD;
                  ta_cnt <= 1'b0;
                  state <= HSRTR_TA;
               end
            end
            HSRTR_TA: begin
               ta_cnt <= 1'b1;
               if (ta_cnt == `HSRTR_LAST_TA) begin
                  data_cnt <= 5'h00;
                  data_shift <= {rd_data[14:0], 1'b0};
                  state <= HSRTR_DATA;
               end
            end
            HSRTR_DATA: begin
               data_shift <= {data_shift[14:0], mdio_in};
               data_cnt <= data_cnt + 5'h01;
               if (data_cnt == `HSRTR_DATA_BITS - 5'd1) begin
                  ones_cnt <= 6'h00;
                  state <= HSRTR_PRE;
               end
            end
            default: begin
               state <= HSRTR_PRE;
            end
         endcase
      end
   end

   // Address register of this device, read-increment steps it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_reg <= 16'h0000;
      end else if (mdc_rise && state == HSRTR_DATA && ours &&
                   data_cnt == `HSRTR_DATA_BITS - 5'd1) begin
         if (op == HSRTR_OP_ADDR) begin
            addr_reg <= {data_shift[14:0], mdio_in};
         end else if (op == HSRTR_OP_READ_INC) begin
            addr_reg <= addr_reg + 16'h0001;
         end
      end
   end

   assign is_read = ours && (op == HSRTR_OP_READ ||
                             op == HSRTR_OP_READ_INC);

   // Pin driver: zero in second turnaround bit, then data MSB first
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mdio_out <= 1'b1;
         mdio_oe_n <= 1'b1;
      end else if (mdc_rise) begin
         if (state == HSRTR_TA && is_read && ta_cnt != `HSRTR_LAST_TA) begin
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b0;
         end else if (state == HSRTR_TA && is_read) begin
            mdio_out <= rd_data[15];
            mdio_oe_n <= 1'b0;
         end else if (state == HSRTR_DATA && is_read &&
                      data_cnt != `HSRTR_DATA_BITS - 5'd1) begin
            mdio_out <= data_shift[15];
         end else begin
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
         end
      end
   end

   // Receive and CDR control decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         adc_track_force <= 1'b0;
         rx_precursor_eq_level <= `HSRTR_EQ_RST;
         rx_precursor_eq_off <= 1'b0;
         rx_precursor_eq_ninths <= `HSRTR_NINTHS_RST;
         cdr_loop_order_select <= `HSRTR_CDRO_RST;
         cdr_second_order <= 1'b1;
         cdr_track_2x <= 1'b0;
         cdr_order_reserved <= 1'b0;
         cdr_vote_threshold <= `HSRTR_VOTE_RST;
         cdr_vote_count <= `HSRTR_COUNT_RST;
         hf_peaking_off <= 1'b0;
         short_channel_cdr_mode <= 1'b0;
         tx_cursor_reduction <= 5'h00;
         tx_cursor_reserved <= 1'b0;
      end else begin
         adc_track_force <= rxcdr_reg[`HSRTR_TRACK_BIT];
         rx_precursor_eq_level <=
            rxcdr_reg[`HSRTR_EQ_MSB:`HSRTR_EQ_LSB];
         rx_precursor_eq_off <=
            rxcdr_reg[`HSRTR_EQ_MSB:`HSRTR_EQ_LSB] == `HSRTR_EQ_OFF;
         rx_precursor_eq_ninths <=
            {rxcdr_reg[`HSRTR_EQ_MSB:`HSRTR_EQ_LSB], 1'b1};
         cdr_loop_order_select <=
            rxcdr_reg[`HSRTR_CDRO_MSB:`HSRTR_CDRO_LSB];
         cdr_second_order <=
            rxcdr_reg[`HSRTR_CDRO_MSB:`HSRTR_CDRO_LSB] != `HSRTR_CDR_FIRST &&
            rxcdr_reg[`HSRTR_CDRO_MSB:`HSRTR_CDRO_LSB] != `HSRTR_CDR_RSVD;
         cdr_track_2x <=
            rxcdr_reg[`HSRTR_CDRO_MSB:`HSRTR_CDRO_LSB] == `HSRTR_CDR_2X;
         cdr_order_reserved <=
            rxcdr_reg[`HSRTR_CDRO_MSB:`HSRTR_CDRO_LSB] == `HSRTR_CDR_RSVD;
         cdr_vote_threshold <=
            rxcdr_reg[`HSRTR_VOTE_MSB:`HSRTR_VOTE_LSB];
         cdr_vote_count <= `HSRTR_VOTE_BASE <<
            rxcdr_reg[`HSRTR_VOTE_MSB:`HSRTR_VOTE_LSB];
         hf_peaking_off <= rxcdr_reg[`HSRTR_PEAK_BIT];
         short_channel_cdr_mode <= rxcdr_reg[`HSRTR_SHORT_BIT];
         tx_cursor_reduction <=
            rxcdr_reg[`HSRTR_CRF_MSB:`HSRTR_CRF_LSB];
         // Flag only; a reserved code still passes through unchanged
         tx_cursor_reserved <=
            rxcdr_reg[`HSRTR_CRF_MSB:`HSRTR_CRF_LSB] >= `HSRTR_CRF_RSVD_LO &&
            rxcdr_reg[`HSRTR_CRF_MSB:`HSRTR_CRF_LSB] <= `HSRTR_CRF_RSVD_HI;
      end
   end

   // Transmit tap decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_pair_invert <= 1'b0;
         tx_pair_invert <= 1'b0;
         tx_post1_tap_weight <= 5'h00;
         tx_pre_tap_weight <= 4'h0;
         tx_post2_tap_weight <= 4'h0;
         tx_post1_negative <= 1'b0;
         tx_post1_steps <= 4'h0;
         tx_pre_negative <= 1'b0;
         tx_pre_steps <= 4'h0;
         tx_post2_negative <= 1'b0;
         tx_post2_steps <= 4'h0;
      end else begin
         rx_pair_invert <= tap_reg[`HSRTR_RXINV_BIT];
         tx_pair_invert <= tap_reg[`HSRTR_TXINV_BIT];
         tx_post1_tap_weight <= tap_reg[`HSRTR_POST1_MSB:`HSRTR_POST1_LSB];
         tx_pre_tap_weight <= tap_reg[`HSRTR_PRE_MSB:`HSRTR_PRE_LSB];
         tx_post2_tap_weight <= tap_reg[`HSRTR_POST2_MSB:`HSRTR_POST2_LSB];
         tx_post1_negative <= tap_negative(
            tap_reg[`HSRTR_POST1_MSB:`HSRTR_POST1_LSB], 1'b0);
         tx_post1_steps <= tap_steps(
            tap_reg[`HSRTR_POST1_MSB:`HSRTR_POST1_LSB], 1'b0);
         tx_pre_negative <= tap_negative(
            {1'b0, tap_reg[`HSRTR_PRE_MSB:`HSRTR_PRE_LSB]}, 1'b1);
         tx_pre_steps <= tap_steps(
            {1'b0, tap_reg[`HSRTR_PRE_MSB:`HSRTR_PRE_LSB]}, 1'b1);
         tx_post2_negative <= tap_negative(
            {1'b0, tap_reg[`HSRTR_POST2_MSB:`HSRTR_POST2_LSB]}, 1'b1);
         tx_post2_steps <= tap_steps(
            {1'b0, tap_reg[`HSRTR_POST2_MSB:`HSRTR_POST2_LSB]}, 1'b1);
      end
   end

   // Pair swap, one register stage
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_data_p <= 1'b0;
         rx_data_n <= 1'b1;
         hs_tx_p <= 1'b0;
         hs_tx_n <= 1'b1;
      end else begin
         rx_data_p <= tap_reg[`HSRTR_RXINV_BIT] ? hs_rx_n : hs_rx_p;
         rx_data_n <= tap_reg[`HSRTR_RXINV_BIT] ? hs_rx_p : hs_rx_n;
         hs_tx_p <= tap_reg[`HSRTR_TXINV_BIT] ? tx_data_n : tx_data_p;
         hs_tx_n <= tap_reg[`HSRTR_TXINV_BIT] ? tx_data_p : tx_data_n;
      end
   end

endmodule // hs_serdes_rx_cdr_tx_tap_regs

// File: shared/hsrtr_defs.svh
`ifndef HSRTR_DEFS_SVH
`define HSRTR_DEFS_SVH

// Management frame layout
`define HSRTR_PREAMBLE_BITS 6'd32
`define HSRTR_HDR_BITS 4'd12
`define HSRTR_DATA_BITS 5'd16
`define HSRTR_LAST_TA 1'b1
`define HSRTR_DEVAD 5'h1E

// Register offsets and reset values
`define HSRTR_RXCDR_OFS 16'h0004
`define HSRTR_TAP_OFS 16'h0005
`define HSRTR_RXCDR_RST 16'h1500
`define HSRTR_TAP_RST 16'h2000
`define HSRTR_UNMAPPED 16'h0000

// Receive and CDR control fields
`define HSRTR_TRACK_BIT 15
`define HSRTR_EQ_MSB 14
`define HSRTR_EQ_LSB 12
`define HSRTR_CDRO_MSB 11
`define HSRTR_CDRO_LSB 10
`define HSRTR_VOTE_MSB 9
`define HSRTR_VOTE_LSB 8
`define HSRTR_RSVD7_BIT 7
`define HSRTR_PEAK_BIT 6
`define HSRTR_SHORT_BIT 5
`define HSRTR_CRF_MSB 4
`define HSRTR_CRF_LSB 0

// Tap and polarity fields
`define HSRTR_RXINV_BIT 15
`define HSRTR_TXINV_BIT 14
`define HSRTR_RSVD13_BIT 13
`define HSRTR_POST1_MSB 12
`define HSRTR_POST1_LSB 8
`define HSRTR_PRE_MSB 7
`define HSRTR_PRE_LSB 4
`define HSRTR_POST2_MSB 3
`define HSRTR_POST2_LSB 0

// Field encodings
`define HSRTR_EQ_OFF 3'h7
`define HSRTR_CDR_FIRST 2'h0
`define HSRTR_CDR_2X 2'h2
`define HSRTR_CDR_RSVD 2'h3
`define HSRTR_VOTE_BASE 6'h04
`define HSRTR_CRF_RSVD_LO 5'h07
`define HSRTR_CRF_RSVD_HI 5'h0F

// Decode outputs while in reset
`define HSRTR_EQ_RST 3'h1
`define HSRTR_NINTHS_RST 4'h3
`define HSRTR_CDRO_RST 2'h1
`define HSRTR_VOTE_RST 2'h1
`define HSRTR_COUNT_RST 6'h08

`endif

// File: shared/hsrtr_pkg.sv
package hsrtr_pkg;

   typedef enum logic [4:0] {
      HSRTR_PRE = 5'b00001,
      HSRTR_ST = 5'b00010,
      HSRTR_HDR = 5'b00100,
      HSRTR_TA = 5'b01000,
      HSRTR_DATA = 5'b10000
   } hsrtr_state_t;

   typedef enum logic [1:0] {
      HSRTR_OP_ADDR = 2'b00,
      HSRTR_OP_WRITE = 2'b01,
      HSRTR_OP_READ_INC = 2'b10,
      HSRTR_OP_READ = 2'b11
   } hsrtr_op_t;

endpackage

// File: rtl/hsrtr_regfile.sv
`timescale 1ns/1ps
`include "hsrtr_defs.svh"

module hsrtr_regfile (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Write side
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   // Read side
   input wire logic [15:0] rd_addr,
   output logic [15:0] rd_data,
   // Stored registers
   output logic [15:0] rxcdr_reg,
   output logic [15:0] tap_reg
);
   import hsrtr_pkg::*;

   localparam logic [15:0] RST_VAL [2] = '{`HSRTR_RXCDR_RST, `HSRTR_TAP_RST};
   localparam logic [15:0] OFS [2] = '{`HSRTR_RXCDR_OFS, `HSRTR_TAP_OFS};

   logic [15:0] store [2];

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_reg
         // Every bit stored as written, reserved ones included
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               store[i] <= RST_VAL[i];
            end else if (wr_en && wr_addr == OFS[i]) begin
               store[i] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data <= `HSRTR_UNMAPPED;
      end else if (rd_addr == `HSRTR_RXCDR_OFS) begin
         rd_data <= store[0];
      end else if (rd_addr == `HSRTR_TAP_OFS) begin
         rd_data <= store[1];
      end else begin
         rd_data <= `HSRTR_UNMAPPED;
      end
   end

   assign rxcdr_reg = store[0];
   assign tap_reg = store[1];

endmodule // hsrtr_regfile

// File: verification/hsrtr_chk_assertions.sv
`timescale 1ns/1ps

module hsrtr_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Management port
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe_n,
   // Field outputs
   input wire logic adc_track_force,
   input wire logic [2:0] rx_precursor_eq_level,
   input wire logic rx_precursor_eq_off,
   input wire logic [3:0] rx_precursor_eq_ninths,
   input wire logic [1:0] cdr_loop_order_select,
   input wire logic cdr_second_order,
   input wire logic cdr_track_2x,
   input wire logic cdr_order_reserved,
   input wire logic [1:0] cdr_vote_threshold,
   input wire logic [5:0] cdr_vote_count,
   input wire logic [4:0] tx_cursor_reduction,
   input wire logic tx_cursor_reserved,
   input wire logic rx_pair_invert,
   input wire logic tx_pair_invert,
   input wire logic [4:0] tx_post1_tap_weight,
   input wire logic [3:0] tx_pre_tap_weight,
   input wire logic [3:0] tx_post2_tap_weight,
   input wire logic tx_post1_negative,
   input wire logic [3:0] tx_post1_steps,
   input wire logic tx_pre_negative,
   input wire logic [3:0] tx_pre_steps,
   input wire logic tx_post2_negative,
   input wire logic [3:0] tx_post2_steps,
   // Pairs
   input wire logic hs_rx_p,
   input wire logic hs_rx_n,
   input wire logic rx_data_p,
   input wire logic rx_data_n,
   input wire logic tx_data_p,
   input wire logic tx_data_n,
   input wire logic hs_tx_p,
   input wire logic hs_tx_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_RST_DEFAULTS: assert property ($past(sys_rst) |->
      {adc_track_force, rx_precursor_eq_level, cdr_loop_order_select,
       cdr_vote_threshold, tx_cursor_reduction, rx_pair_invert,
       tx_pair_invert, tx_post1_tap_weight, tx_pre_tap_weight,
       tx_post2_tap_weight} == 28'h1500000)
      else $error("field outputs not at defaults after reset");
   AST_EQ_DECODE: assert property (
      rx_precursor_eq_ninths == {rx_precursor_eq_level, 1'b1} &&
      rx_precursor_eq_off == (rx_precursor_eq_level == 3'h7))
      else $error("precursor decode wrong");
   AST_CDR_ORDER: assert property (
      cdr_second_order == (cdr_loop_order_select inside {2'h1, 2'h2}) &&
      cdr_track_2x == (cdr_loop_order_select == 2'h2) &&
      cdr_order_reserved == (cdr_loop_order_select == 2'h3))
      else $error("loop order decode wrong");
   AST_VOTE_COUNT: assert property (
      cdr_vote_count == (cdr_vote_threshold == 2'h0 ? 6'h04 :
                         cdr_vote_threshold == 2'h1 ? 6'h08 :
                         cdr_vote_threshold == 2'h2 ? 6'h10 : 6'h20))
      else $error("vote count decode wrong");
   AST_CRF_RSVD: assert property (
      tx_cursor_reserved == (tx_cursor_reduction inside {[5'h07:5'h0F]}))
      else $error("cursor reserved flag wrong");
   AST_TAP_SIGN: assert property (
      tx_post1_negative == tx_post1_tap_weight[4] &&
      tx_post1_steps == tx_post1_tap_weight[3:0] &&
      tx_pre_negative == tx_pre_tap_weight[3] &&
      tx_pre_steps == {1'b0, tx_pre_tap_weight[2:0]} &&
      tx_post2_negative == tx_post2_tap_weight[3] &&
      tx_post2_steps == {1'b0, tx_post2_tap_weight[2:0]})
      else $error("tap sign or magnitude wrong");
   AST_RX_SWAP: assert property (!$past(sys_rst) |->
      {rx_data_p, rx_data_n} == (rx_pair_invert ?
      {$past(hs_rx_n), $past(hs_rx_p)} : {$past(hs_rx_p), $past(hs_rx_n)}))
      else $error("receive pair swap wrong");
   AST_TX_SWAP: assert property (!$past(sys_rst) |->
      {hs_tx_p, hs_tx_n} == (tx_pair_invert ?
      {$past(tx_data_n), $past(tx_data_p)} :
      {$past(tx_data_p), $past(tx_data_n)}))
      else $error("transmit pair swap wrong");
   AST_MDIO_STEADY: assert property (
      ($changed(mdio_out) || $changed(mdio_oe_n)) |->
      $past(mdc) && !$past(mdc, 2))
      else $error("management output moved off a clock rise");
endmodule // hsrtr_chk

bind hs_serdes_rx_cdr_tx_tap_regs hsrtr_chk chk_u (.*);

// File: verification/hsrtr_sta.sv
`timescale 1ns/1ps

module hsrtr_sta (
   // Clock
   input wire logic core_clk,
   // Management lines
   output logic mdc,
   output logic sta_bit,
   output logic sta_en,
   input wire logic mdio_line
);
   initial begin
      mdc = 1'b0;
      sta_bit = 1'b1;
      sta_en = 1'b0;
   end

   // Clock rests low between frames; line released floats to pull-up
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] da, input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] fr;
      fr = {32'hFFFFFFFF, 2'b00, op, pa, da, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(posedge core_clk);
         mdc <= 1'b0;
         sta_bit <= fr[63 - i];
         sta_en <= !(op[1] && i >= 46);
         repeat (3) @(posedge core_clk);
         // Device bit from the previous rise is still standing here
         if (i >= 48) rd = {rd[14:0], mdio_line};
         @(posedge core_clk);
         mdc <= 1'b1;
         repeat (3) @(posedge core_clk);
      end
      @(posedge core_clk);
      mdc <= 1'b0;
      sta_en <= 1'b0;
   endtask
endmodule // hsrtr_sta

// File: verification/hs_serdes_rx_cdr_tx_tap_regs_tb.sv
`timescale 1ns/1ps

module hs_serdes_rx_cdr_tx_tap_regs_tb;
   import hsrtr_pkg::*;
   logic core_clk, sys_rst, mdc, mdio_out, mdio_oe_n, sta_bit, sta_en;
   logic hs_rx_p, hs_rx_n, tx_data_p, tx_data_n;
   logic [4:0] port_addr;
   logic [15:0] shadow [2];
   logic [15:0] rd, w;
   logic [15:0] corner [4] = '{16'hFF7F, 16'h0000, 16'h0C07, 16'h2A2F};
   wire mdio_line = !mdio_oe_n ? mdio_out : (sta_en ? sta_bit : 1'b1);
   wire [14:0] f4, f5;
   int n_errors, tests_run, seed;

   hs_serdes_rx_cdr_tx_tap_regs dut_u (.core_clk(core_clk),
      .sys_rst(sys_rst), .port_addr(port_addr), .mdc(mdc),
      .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
      .adc_track_force(f4[14]), .rx_precursor_eq_level(f4[13:11]),
      .rx_precursor_eq_off(), .rx_precursor_eq_ninths(),
      .cdr_loop_order_select(f4[10:9]), .cdr_second_order(),
      .cdr_track_2x(), .cdr_order_reserved(),
      .cdr_vote_threshold(f4[8:7]), .cdr_vote_count(),
      .hf_peaking_off(f4[6]), .short_channel_cdr_mode(f4[5]),
      .tx_cursor_reduction(f4[4:0]), .tx_cursor_reserved(),
      .rx_pair_invert(f5[14]), .tx_pair_invert(f5[13]),
      .tx_post1_tap_weight(f5[12:8]), .tx_pre_tap_weight(f5[7:4]),
      .tx_post2_tap_weight(f5[3:0]), .tx_post1_negative(),
      .tx_post1_steps(), .tx_pre_negative(), .tx_pre_steps(),
      .tx_post2_negative(), .tx_post2_steps(), .hs_rx_p(hs_rx_p),
      .hs_rx_n(hs_rx_n), .rx_data_p(), .rx_data_n(),
      .tx_data_p(tx_data_p), .tx_data_n(tx_data_n), .hs_tx_p(),
      .hs_tx_n());

   hsrtr_sta sta_u (.core_clk(core_clk), .mdc(mdc), .sta_bit(sta_bit),
      .sta_en(sta_en), .mdio_line(mdio_line));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
      {hs_rx_p, hs_rx_n, tx_data_p, tx_data_n} <= 4'($urandom);

   function automatic logic [15:0] exp4(input logic [15:0] v);
      return {1'b0, v[15:8], v[6:0]};
   endfunction
   function automatic logic [15:0] exp5(input logic [15:0] v);
      return {1'b0, v[15:14], v[12:0]};
   endfunction

   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      sta_u.xfer(HSRTR_OP_ADDR, port_addr, 5'h1E, a, rd);
      sta_u.xfer(HSRTR_OP_WRITE, port_addr, 5'h1E, d, rd);
   endtask
   task automatic rdr(input logic [15:0] a, output logic [15:0] d);
      sta_u.xfer(HSRTR_OP_ADDR, port_addr, 5'h1E, a, d);
      sta_u.xfer(HSRTR_OP_READ, port_addr, 5'h1E, 16'h0000, d);
   endtask

   task automatic check_all();
      rdr(16'h0004, rd);
      chk("rxcdr", shadow[0], rd);
      rdr(16'h0005, rd);
      chk("tap", shadow[1], rd);
      chk("rxcdr fields", exp4(shadow[0]), {1'b0, f4});
      chk("tap fields", exp5(shadow[1]), {1'b0, f5});
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge core_clk);
      n_errors++;
      results();
   end

   initial begin
      sys_rst = 1'b1;
      port_addr = 5'h00;
      seed = $urandom(32'h50be6efb);
      @(posedge core_clk);
      port_addr <= 5'($urandom);
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      shadow = '{16'h1500, 16'h2000};
      check_all();
      $display("test defaults done");
      for (int k = 0; k < 9; k++) begin
         w = (k < 4) ? corner[k] : 16'($urandom);
         shadow[0] = w & 16'hFF7F;
         shadow[1] = (k == 0) ? 16'hFFFF : 16'($urandom);
         wr(16'h0004, shadow[0]);
         wr(16'h0005, shadow[1]);
         check_all();
      end
      $display("test random write done");
      wr(16'h0006, 16'hA5A5);
      rdr(16'h0006, rd);
      chk("unmapped", 16'h0000, rd);
      sta_u.xfer(HSRTR_OP_WRITE, port_addr, 5'h1F, 16'h1234, rd);
      sta_u.xfer(HSRTR_OP_READ, port_addr + 5'h01, 5'h1E, 16'h0000, rd);
      chk("other port", 16'hFFFF, rd);
      check_all();
      $display("test refusals done");
      sta_u.xfer(HSRTR_OP_ADDR, port_addr, 5'h1E, 16'h0004, rd);
      sta_u.xfer(HSRTR_OP_READ_INC, port_addr, 5'h1E, 16'h0000, rd);
      chk("inc first", shadow[0], rd);
      sta_u.xfer(HSRTR_OP_READ, port_addr, 5'h1E, 16'h0000, rd);
      chk("inc second", shadow[1], rd);
      $display("test increment done");
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      shadow = '{16'h1500, 16'h2000};
      check_all();
      $display("test second reset done");
      results();
   end
endmodule // hs_serdes_rx_cdr_tx_tap_regs_tb
